// file: design/fl_ctrl.sv
/*
 * flash led control registers: serial slave, register bank, mode logic,
 * flash duration timer, indicator timer and alert pulse.
 * assumes open-drain sda resolved outside; scl slow against core_clk.
 */
`timescale 1ns/1ps
module fl_ctrl #(
   parameter logic [6:0] DEV_ADDR    = fl_pkg::DEV_ADDR_DEF,
   parameter int         TICK_CYCLES = int'(fl_pkg::TICK_OSC_CYC),
   parameter int         ALERT_CYCLES = fl_pkg::ALERT_CYC
) (
   input  wire logic              core_clk,         // core clock
   input  wire logic              osc_clk,          // internal oscillator
   input  wire logic              rst,              // async reset, high
   input  wire logic              scl_in,           // serial clock pin
   input  wire logic              sda_in,           // serial data pin level
   output logic                   sda_out,          // always low
   output logic                   sda_oe_n,         // low pulls sda low
   input  wire logic              flash_strobe_pin, // external strobe
   input  wire fl_pkg::fl_sense_t sense,            // analog fault levels
   output logic                   alert_n_pin,      // attention, low active
   output fl_pkg::fl_drive_t      drive             // mode and level outputs
);
   import fl_pkg::*;

   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_reg,
      st_wdat,
      st_rdat
   } fl_state_t;

   logic       tick_tgl;
   logic [8:0] sync_s;
   logic       scl_s;
   logic       sda_s;
   logic       strobe_s;
   logic       tick_s;
   fl_sense_t  sense_s;

   fl_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .osc_clk(osc_clk),
      .rst    (rst),
      .tgl_q  (tick_tgl)
   );

   fl_sync #(
      .W(9)
   ) u_sync (
      .clk(core_clk),
      .rst(rst),
      .d  ({scl_in, sda_in, flash_strobe_pin, tick_tgl, sense}),
      .q  (sync_s)
   );

   assign scl_s    = sync_s[8];
   assign sda_s    = sync_s[7];
   assign strobe_s = sync_s[6];
   assign tick_s   = sync_s[5];
   assign sense_s  = sync_s[4:0];

   // edge history, read only after the synchroniser
   logic scl_q;
   logic sda_q;
   logic tick_q;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic tick;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
         tick_q <= 1'b0;
      end else begin
         scl_q  <= scl_s;
         sda_q  <= sda_s;
         tick_q <= tick_s;
      end
   end

   assign rise  = scl_s & ~scl_q;
   assign fall  = ~scl_s & scl_q;
   assign start = scl_s & scl_q & sda_q & ~sda_s;
   assign stop  = scl_s & scl_q & ~sda_q & sda_s;
   assign tick  = tick_s ^ tick_q;

   // register state
   logic [7:0] cmd_q;
   logic [7:0] cmd_d;
   logic [7:0] dim_q;
   logic [7:0] dim_d;
   logic [7:0] ind_q;
   logic [7:0] ind_d;
   logic [3:0] flags_q;
   logic [3:0] flags_d;
   logic       fon_q;
   logic       fon_d;

   function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] c,
                                          input logic [7:0] dm, input logic [7:0] in,
                                          input logic [7:0] stat);
      case (a) // [RULE3]
         REG_CMD:    rd_byte = c;
         REG_DIM:    rd_byte = dm;
         REG_IND:    rd_byte = in;
         REG_STATUS: rd_byte = stat;
         default:    rd_byte = 8'h00;
      endcase
   endfunction

   logic [7:0] status;
   assign status = {1'b0, fon_q, flags_q, 1'b0, sense_s.vout_not_ok}; // [RULE20]

   // serial slave
   fl_state_t  st_q;
   fl_state_t  st_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [7:0] rx_q;
   logic [7:0] rx_d;
   logic [7:0] tx_q;
   logic [7:0] tx_d;
   logic [7:0] ptr_q;
   logic [7:0] ptr_d;
   logic       rw_q;
   logic       rw_d;
   logic       mack_q;
   logic       mack_d;
   logic       oe_n_q;
   logic       oe_n_d;
   logic       wr_en;
   logic       rd_done;

   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      rx_d    = rx_q;
      tx_d    = tx_q;
      ptr_d   = ptr_q;
      rw_d    = rw_q;
      mack_d  = mack_q;
      oe_n_d  = oe_n_q;
      wr_en   = 1'b0;
      rd_done = 1'b0;
      if (stop) begin
         st_d   = st_idle;
         oe_n_d = 1'b1;
      end else if (start) begin
         st_d   = st_addr;
         cnt_d  = 4'h0;
         oe_n_d = 1'b1;
      end else if (st_q != st_idle && rise) begin
         if (cnt_q < 4'h8) begin
            rx_d = {rx_q[6:0], sda_s};
         end else begin
            mack_d = ~sda_s; // [RULE2]
         end
         cnt_d = cnt_q + 4'h1;
      end else if (st_q != st_idle && fall && cnt_q == 4'h8) begin
         oe_n_d = 1'b0;
         case (st_q)
            st_addr: begin
               rw_d = rx_q[0];
               if (rx_q[7:1] != DEV_ADDR) begin
                  st_d   = st_idle;
                  oe_n_d = 1'b1;
               end
            end
            st_reg: begin
               ptr_d = rx_q; // [RULE22]
            end
            st_wdat: begin
               wr_en = 1'b1;
               ptr_d = ptr_q + 8'h01; // [RULE22]
            end
            st_rdat: begin
               // let the master drive its acknowledge
               oe_n_d  = 1'b1;
               rd_done = 1'b1;
               ptr_d   = ptr_q + 8'h01; // [RULE1]
            end
            default: begin
               oe_n_d = 1'b1;
            end
         endcase
      end else if (st_q != st_idle && fall && cnt_q == 4'h9) begin
         cnt_d  = 4'h0;
         oe_n_d = 1'b1;
         case (st_q)
            st_addr: begin
               if (rw_q) begin
                  st_d   = st_rdat;
                  tx_d   = rd_byte(ptr_q, cmd_q, dim_q, ind_q, status);
                  oe_n_d = tx_d[7];
               end else begin
                  st_d = st_reg;
               end
            end
            st_reg: begin
               st_d = st_wdat;
            end
            st_rdat: begin
               if (mack_q) begin // [RULE2]
                  tx_d   = rd_byte(ptr_q, cmd_q, dim_q, ind_q, status);
                  oe_n_d = tx_d[7];
               end else begin
                  st_d = st_idle;
               end
            end
            default: begin
               st_d = st_q;
            end
         endcase
      end else if (st_q == st_rdat && fall && cnt_q != 4'h0) begin
         tx_d   = {tx_q[6:0], 1'b0};
         oe_n_d = tx_q[6];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q   <= st_idle;
         cnt_q  <= 4'h0;
         rx_q   <= 8'h00;
         tx_q   <= 8'h00;
         ptr_q  <= 8'h00;
         rw_q   <= 1'b0;
         mack_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         rx_q   <= rx_d;
         tx_q   <= tx_d;
         ptr_q  <= ptr_d;
         rw_q   <= rw_d;
         mack_q <= mack_d;
         oe_n_q <= oe_n_d;
      end
   end

   // control and timers
   logic [3:0]  fcnt_q;
   logic [3:0]  fcnt_d;
   logic [3:0]  icnt_q;
   logic [3:0]  icnt_d;
   logic        ion_q;
   logic        ion_d;
   logic [15:0] acnt_q;
   logic [15:0] acnt_d;
   logic        gate;
   logic        torch;
   logic        ready;
   logic [3:0]  raise;
   fl_drive_t   drive_d;

   assign gate  = cmd_q[CMD_POWER] & cmd_q[CMD_STROBE] & strobe_s; // [RULE5] [RULE7]
   assign torch = cmd_q[CMD_POWER] & cmd_q[CMD_TORCH] & ~gate;    // [RULE10]
   assign ready = cmd_q[CMD_POWER] & ~gate & ~torch;              // [RULE4]
   assign raise = {sense_s.led_fault, sense_s.temp_warn, sense_s.temp_hot,
                   sense_s.chip_hot} & ~flags_q;

   always_comb begin
      cmd_d  = cmd_q;
      dim_d  = dim_q;
      ind_d  = ind_q;
      fon_d  = gate;
      fcnt_d = fcnt_q;
      icnt_d = icnt_q;
      ion_d  = ion_q;
      acnt_d = (acnt_q != 16'h0000) ? acnt_q - 16'h0001 : acnt_q;
      // set wins over the read clear
      flags_d = rd_done && ptr_q == REG_STATUS ? 4'h0 : flags_q; // [RULE21]
      flags_d = flags_d | {sense_s.led_fault, sense_s.temp_warn, sense_s.temp_hot,
                           sense_s.chip_hot};
      if (raise != 4'h0) begin
         acnt_d = 16'(ALERT_CYCLES);
      end
      if (gate && !fon_q) begin
         fcnt_d = cmd_q[3:0]; // [RULE13] [RULE12]
      end else if (gate && fcnt_q == 4'h0) begin
         // duration field stays as written
         cmd_d[CMD_STROBE] = 1'b0;              // [RULE14] [RULE15]
         acnt_d            = 16'(ALERT_CYCLES); // [RULE20]
      end else if (gate && tick) begin
         fcnt_d = fcnt_q - 4'h1; // [RULE23]
      end
      if (tick && ion_q && ind_q[3:0] != ON_TIME_FOREVER) begin // [RULE18]
         if (icnt_q <= 4'h1) begin
            ion_d = 1'b0;
         end else begin
            icnt_d = icnt_q - 4'h1;
         end
      end
      // a host write lands last, so a reload beats the timeout
      if (wr_en) begin
         case (ptr_q)
            REG_CMD: begin
               cmd_d = rx_q;
               if (fon_q) begin
                  fcnt_d = rx_q[3:0];
               end
            end
            REG_DIM: begin
               dim_d = rx_q;
            end
            REG_IND: begin
               ind_d  = rx_q;
               ion_d  = rx_q[7:4] != 4'h0; // [RULE16] [RULE19]
               icnt_d = rx_q[3:0];
            end
            default: begin
               cmd_d = cmd_d;
            end
         endcase
      end
      drive_d.power_on    = cmd_q[CMD_POWER];
      drive_d.flash_mode  = gate;
      drive_d.torch_mode  = torch;
      drive_d.temp_mon_en = gate | torch | (ready & cmd_q[CMD_TEMP]); // [RULE11]
      if (gate) begin
         drive_d.led_level = dim_q[3:0]; // [RULE8]
      end else if (torch) begin
         drive_d.led_level = dim_q[7:4]; // [RULE9]
      end else begin
         drive_d.led_level = 4'h0;
      end
      drive_d.ind_level = (ready && ion_q) ? ind_q[7:4] : 4'h0; // [RULE17]
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmd_q       <= REG_RESET;
         dim_q       <= REG_RESET;
         ind_q       <= REG_RESET;
         flags_q     <= 4'h0;
         fon_q       <= 1'b0;
         fcnt_q      <= 4'h0;
         icnt_q      <= 4'h0;
         ion_q       <= 1'b0;
         acnt_q      <= 16'h0000;
         alert_n_pin <= 1'b1;
         drive       <= '0;
         sda_out     <= 1'b0;
         sda_oe_n    <= 1'b1;
      end else begin
         cmd_q       <= cmd_d;
         dim_q       <= dim_d;
         ind_q       <= ind_d;
         flags_q     <= flags_d;
         fon_q       <= fon_d;
         fcnt_q      <= fcnt_d;
         icnt_q      <= icnt_d;
         ion_q       <= ion_d;
         acnt_q      <= acnt_d;
         alert_n_pin <= acnt_d == 16'h0000;
         drive       <= drive_d;
         sda_out     <= 1'b0;
         sda_oe_n    <= oe_n_d;
      end
   end
endmodule

// file: design/fl_pkg.sv
/*
 * constants, field layouts and carrier types of the flash led control block.
 * assumes a 125 MHz core clock and a free-running internal oscillator clock.
 */
// Overview of operation
// RULE1: read pointer advances after each sent byte
// RULE2: master ack continues read, no ack ends
// RULE3: offsets 0..2 read/write, 3 status read only
// RULE4: power enable selects ready mode, else idle
// RULE5: flash gate is strobe enable and pin
// RULE6: host holds pin high or pulses it
// RULE7: no flash without power enable set
// RULE8: flash level is dimming bits 3:0
// RULE9: torch level is dimming bits 7:4
// RULE10: torch enable from ready gives torch mode
// RULE11: temp comparators forced on in torch, flash
// RULE12: duration code counts 100 ms steps
// RULE13: flash entry loads down counter with duration
// RULE14: zero count clears strobe enable, raises alert
// RULE15: duration field kept after countdown ends
// RULE16: indicator level linear; nonzero write starts timer
// RULE17: indicator driven only in ready mode
// RULE18: on time code times 100 ms, 15 continuous
// RULE19: only level writes start or stop indicator
// RULE20: flash end drops running bit, 11 us alert
// RULE21: status read clears latched fault flags
// RULE22: register address byte sets start pointer
// RULE23: 100 ms tick from oscillator drives both timers
package fl_pkg;
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_DIM = 8'h01;
   localparam logic [7:0] REG_IND = 8'h02;
   localparam logic [7:0] REG_STATUS = 8'h03;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int CMD_POWER = 7;
   localparam int CMD_STROBE = 6;
   localparam int CMD_TORCH = 5;
   localparam int CMD_TEMP = 4;
   localparam logic [3:0] ON_TIME_FOREVER = 4'hF;
   // bus address of the device; value is arbitrary
   localparam logic [6:0] DEV_ADDR_DEF = 7'h2A;
   localparam int CORE_PERIOD_PS = 8000;
   localparam int OSC_PERIOD_PS = 6000;
   localparam int ALERT_US = 11;
   localparam int ALERT_CYC = (ALERT_US * 1000000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
   localparam int TICK_MS = 100;
   localparam longint TICK_OSC_CYC = (64'(TICK_MS) * 64'd1000000000) / 64'(OSC_PERIOD_PS);

   typedef struct packed {
      logic led_fault;
      logic temp_warn;
      logic temp_hot;
      logic chip_hot;
      logic vout_not_ok;
   } fl_sense_t;

   typedef struct packed {
      logic       power_on;
      logic       flash_mode;
      logic       torch_mode;
      logic       temp_mon_en;
      logic [3:0] led_level;
      logic [3:0] ind_level;
   } fl_drive_t;
endpackage

// file: design/fl_sync.sv
/*
 * two-stage synchroniser for a vector of unrelated levels.
 * assumes each bit is a slow level or a toggle; bits are not coherent.
 */
`timescale 1ns/1ps
module fl_sync #(
   parameter int W = 1
) (
   input  wire logic         clk, // destination clock
   input  wire logic         rst, // async reset, high
   input  wire logic [W-1:0] d,   // asynchronous levels
   output logic      [W-1:0] q    // synchronised levels
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// file: design/fl_tick.sv
/*
 * 100 ms time base on the internal oscillator clock; emits a toggle.
 * assumes the receiving domain synchronises the toggle and edge-detects it.
 */
`timescale 1ns/1ps
module fl_tick #(
   parameter int TICK_CYCLES = int'(fl_pkg::TICK_OSC_CYC)
) (
   input  wire logic osc_clk, // internal oscillator
   input  wire logic rst,     // async reset, high
   output logic      tgl_q    // flips once per tick
);
   import fl_pkg::*;
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic        tgl_d;

   always_comb begin
      cnt_d = cnt_q + 32'h0000_0001;
      tgl_d = tgl_q;
      if (cnt_q >= 32'(TICK_CYCLES - 1)) begin // [RULE23]
         cnt_d = 32'h0000_0000;
         tgl_d = ~tgl_q;
      end
   end

   always_ff @(posedge osc_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 32'h0000_0000;
         tgl_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tgl_q <= tgl_d;
      end
   end
endmodule

// file: verif/fl_ctrl_assertions.sv
/* port checks of the flash led control block.
   assumes binding to fl_ctrl; all checks run on core_clk. */
`timescale 1ns/1ps
module fl_ctrl_assertions #(
   parameter int TICK_CYCLES  = 50,
   parameter int ALERT_CYCLES = 20
) (
   input wire logic              core_clk,         // core clock
   input wire logic              osc_clk,          // oscillator
   input wire logic              rst,              // async reset, high
   input wire logic              scl_in,           // serial clock
   input wire logic              sda_in,           // sda level
   input wire logic              sda_out,          // sda drive value
   input wire logic              sda_oe_n,         // low pulls sda
   input wire logic              flash_strobe_pin, // strobe pin
   input wire fl_pkg::fl_sense_t sense,            // fault levels
   input wire logic              alert_n_pin,      // attention
   input wire fl_pkg::fl_drive_t drive             // mode outputs
);
   import fl_pkg::*;
   logic [15:0] lo_q;
   logic [15:0] lo_d;
   // length of the current alert pulse, zero while released
   always_comb lo_d = alert_n_pin ? 16'h0000 : lo_q + 16'h0001;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         lo_q <= 16'h0000;
      else
         lo_q <= lo_d;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_flash_pwr;
      drive.flash_mode |-> drive.power_on;
   endproperty
   a_flash_pwr: assert property (p_flash_pwr) else $error("flash without power");
   property p_pin_gate;
      (!flash_strobe_pin) [*5] |-> !drive.flash_mode;
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("flash with pin low");
   property p_torch_pwr;
      drive.torch_mode |-> drive.power_on && !drive.flash_mode;
   endproperty
   a_torch_pwr: assert property (p_torch_pwr) else $error("torch out of ready");
   property p_temp_on;
      drive.flash_mode || drive.torch_mode |-> drive.temp_mon_en;
   endproperty
   a_temp_on: assert property (p_temp_on) else $error("temp monitor off");
   property p_ind_ready;
      drive.ind_level != 4'h0 |-> drive.power_on && !drive.flash_mode && !drive.torch_mode;
   endproperty
   a_ind_ready: assert property (p_ind_ready) else $error("indicator out of ready");
   property p_led_zero;
      !drive.flash_mode && !drive.torch_mode |-> drive.led_level == 4'h0;
   endproperty
   a_led_zero: assert property (p_led_zero) else $error("led level while idle");
   property p_alert_len;
      $rose(alert_n_pin) |-> lo_q == 16'(ALERT_CYCLES);
   endproperty
   a_alert_len: assert property (p_alert_len) else $error("alert pulse length");
   property p_sda_low;
      $fell(sda_oe_n) |-> !scl_in && !sda_out;
   endproperty
   a_sda_low: assert property (p_sda_low) else $error("sda pulled with scl high");
endmodule

// file: verif/fl_host.sv
/* host bus master model: drives scl and its share of sda.
   assumes sda is resolved with a pull-up by the bench. */
`timescale 1ns/1ps
module fl_host #(
   parameter int H = 10
) (
   input  wire logic core_clk, // core clock
   input  wire logic sda,      // resolved sda level
   output logic      scl_q,    // serial clock
   output logic      sda_q     // low pulls sda
);
   initial begin
      scl_q = 1'b1;
      sda_q = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic s(input logic c, input logic d);
      scl_q <= c;
      sda_q <= d;
      wt(H);
   endtask
   // sda moves only two edges after scl fell, so no false start or stop
   task automatic bitx(input logic b, output logic r);
      sda_q <= b;
      wt(H);
      scl_q <= 1'b1;
      wt(H);
      r = sda;
      scl_q <= 1'b0;
      wt(2);
   endtask
   task automatic start();
      s(1'b0, 1'b1);
      s(1'b1, 1'b1);
      s(1'b1, 1'b0);
      s(1'b0, 1'b0);
   endtask
   task automatic stop();
      s(1'b0, 1'b0);
      s(1'b1, 1'b0);
      s(1'b1, 1'b1);
   endtask
   task automatic xbyte(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                        output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
      bitx(ai, a);
      ack = !a;
   endtask
endmodule

// file: verif/flash_led_control_registers_tb_top.sv
/* self-checking bench of the flash led control block.
   assumes the host model drives the bus and the checker is bound in. */
`timescale 1ns/1ps
module flash_led_control_registers_tb_top;
   import fl_pkg::*;
   localparam int TICKS = 2000;
   localparam int TK    = TICKS * 6 / 8; // tick in core cycles
   logic       core_clk, osc_clk, rst, scl, sda, oe_n, so, pin, alert_n, h_sda;
   fl_sense_t  sense;
   fl_drive_t  drive;
   int         err_total, total_checks;
   logic [7:0] q[$];
   logic [7:0] d0, d1, d2, t;
   time        t0;
   assign sda = h_sda & (oe_n | so);
   fl_ctrl #(.TICK_CYCLES(TICKS), .ALERT_CYCLES(20)) u_dut (.core_clk, .osc_clk, .rst,
      .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe_n(oe_n), .flash_strobe_pin(pin),
      .sense, .alert_n_pin(alert_n), .drive);
   fl_host u_host (.core_clk, .sda, .scl_q(scl), .sda_q(h_sda));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic adr(input logic [7:0] a);
      logic [7:0] r;
      logic k;
      u_host.start();
      u_host.xbyte({DEV_ADDR_DEF, 1'b0}, 1'b1, r, k);
      chk(k, 1);
      u_host.xbyte(a, 1'b1, r, k);
      chk(k, 1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
      logic [7:0] r;
      logic k;
      adr(a);
      foreach (d[i]) u_host.xbyte(d[i], 1'b1, r, k);
      u_host.stop();
   endtask
   task automatic rd(input logic [7:0] a, input int n);
      logic [7:0] r;
      logic k;
      adr(a);
      u_host.start();
      u_host.xbyte({DEV_ADDR_DEF, 1'b1}, 1'b1, r, k);
      q = {};
      for (int i = 0; i < n; i++) begin
         u_host.xbyte(8'hFF, i == n - 1, r, k);
         q.push_back(r);
      end
      u_host.stop();
   endtask
   function automatic logic [7:0] st_exp(input fl_sense_t s);
      return {2'b00, s.led_fault, s.temp_warn, s.temp_hot, s.chip_hot, 1'b0, s.vout_not_ok};
   endfunction
   task automatic summarize();
      if (err_total == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      osc_clk = 1'b0;
      #1.3;
      forever #3 osc_clk = ~osc_clk;
   end
   initial begin
      wt(80000);
      err_total++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      pin = 1'b0;
      sense = '0;
      void'($urandom(47));
      wt(5);
      rst <= 1'b0;
      wt(4);
      rd(8'h00, 4);
      foreach (q[i]) chk(q[i], 8'h00);
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      // last byte lands on the read-only status place and must vanish
      wr(8'h00, {d0, d1, d2, 8'h5A});
      rd(8'h01, 4);
      chk(q[0], d1);
      chk(q[1], d2);
      chk(q[2], 8'h00);
      chk(q[3], 8'h00);
      rd(8'h00, 1);
      chk(q[0], d0);
      t = 8'($urandom);
      wr(8'h00, {8'h00, t});
      pin <= 1'b1;
      wr(8'h00, {8'hC2});
      for (int i = 0; i < 100 && drive.flash_mode !== 1'b1; i++) wt(1);
      t0 = $time;
      chk(drive.flash_mode, 1);
      chk(drive.led_level, t[3:0]);
      rd(8'h03, 1);
      chk(q[0], 8'h40);
      for (int i = 0; i < 5000 && alert_n !== 1'b0; i++) wt(1);
      chk(($time - t0) / 8 > TK - 60 && ($time - t0) / 8 < 2 * TK + 20, 1);
      wt(3);
      chk(drive.flash_mode, 0);
      rd(8'h00, 2);
      chk(q[0], 8'h82);
      chk(q[1], t);
      rd(8'h03, 1);
      chk(q[0], 8'h00);
      wr(8'h00, {8'h45});
      wt(20);
      chk({drive.power_on, drive.flash_mode}, 0);
      pin <= 1'b0;
      wr(8'h00, {8'hC5});
      wt(10);
      chk(drive.flash_mode, 0);
      pin <= 1'b1;
      wt(10);
      chk(drive.flash_mode, 1);
      pin <= 1'b0;
      wt(10);
      chk(drive.flash_mode, 0);
      wr(8'h00, {8'hA0});
      wt(5);
      chk({drive.torch_mode, drive.temp_mon_en}, 2'b11);
      chk(drive.led_level, t[7:4]);
      wr(8'h00, {8'h90});
      wt(5);
      chk({drive.torch_mode, drive.temp_mon_en}, 2'b01);
      wr(8'h00, {8'h80});
      wt(5);
      chk({drive.power_on, drive.temp_mon_en}, 2'b10);
      d2 = {4'($urandom_range(1, 15)), 4'h2};
      wr(8'h02, {d2});
      wt(5);
      chk(drive.ind_level, d2[7:4]);
      wt(TK - 200);
      chk(drive.ind_level, d2[7:4]);
      wt(TK + 300);
      chk(drive.ind_level, 0);
      wr(8'h02, {8'h3F});
      wt(4 * TK);
      chk(drive.ind_level, 4'h3);
      wr(8'h00, {8'hA0});
      wt(5);
      chk(drive.ind_level, 0);
      wr(8'h00, {8'h80});
      wt(5);
      chk(drive.ind_level, 4'h3);
      wr(8'h02, {8'h0F});
      wt(5);
      chk(drive.ind_level, 0);
      repeat (3) begin
         sense <= fl_sense_t'(5'($urandom_range(1, 31)));
         wt(10);
         t = st_exp(sense);
         // output-voltage bit is a live level, not latched: keep it up for both reads
         sense <= fl_sense_t'({4'h0, sense.vout_not_ok});
         rd(8'h03, 1);
         chk(q[0], t);
         rd(8'h03, 1);
         chk(q[0], {7'h00, t[0]});
      end
      summarize();
   end
endmodule
bind fl_ctrl fl_ctrl_assertions #(.TICK_CYCLES(TICK_CYCLES), .ALERT_CYCLES(ALERT_CYCLES)) u_chk (
   .core_clk, .osc_clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe_n, .flash_strobe_pin,
   .sense, .alert_n_pin, .drive);
